// file: design/scl_pkg.sv
/*
  Constants, register map and state codes for the serial configuration
  pin logic. Assumes a single 25 MHz system clock and AXI4-Lite access.
*/
// How it works
// - Passive mode: clock pin is input, data bit taken on its rising edge.
// - Active mode: device drives the clock pin, internal pull-up always on.
// - After configuration clock pin tri-stated; its toggling is ignored.
// - Configuration data arrives one bit at a time on one data pin.
// - Disabled optional pins are user I/O, tri-stated with pull-ups meanwhile.
// - Enabled user start-up clock paces the initialization sequence.
// - Init-done undriven while request low and at configuration start.
// - Init-done driven low once first frame enables it.
// - Init-done released when initialization ends; user mode entered then.
// - Enabled global output enable low tri-states every I/O pin.
// - Enabled global clear low clears every device register.
// - Config-complete held low until all data received without error.
package scl_pkg;

  localparam int ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_FRAMES   = 5'h08;
  localparam logic [ADDR_W-1:0] REG_OPTIONS  = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h14;

  // Control fields
  localparam int CTRL_AS_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Option bits inside the first frame
  localparam int OPT_USER_CLK = 0;
  localparam int OPT_INIT_DONE = 1;
  localparam int OPT_GLOBAL_OE = 2;
  localparam int OPT_GLOBAL_CLR = 3;

  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam int BIT_CNT_W = 5;
  localparam int FRAME_COUNT = 4;
  localparam int FRAME_CNT_W = 8;
  localparam logic [31:0] END_WORD = 32'hA5C3_0F5A;

  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_COMPLETE = 1;
  localparam int IRQ_USER = 2;
  localparam int IRQ_FAIL = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  // Timing
  localparam int CLK_NS = 40;
  localparam int AS_HALF_NS = 80;
  localparam int AS_HALF_CYC = (AS_HALF_NS / CLK_NS < 1) ? 1
                               : AS_HALF_NS / CLK_NS;
  localparam int INIT_CYCLES = 16;
  localparam int CNT_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_LOAD  = 5'b00010,
    ST_INIT  = 5'b00100,
    ST_USER  = 5'b01000,
    ST_FAIL  = 5'b10000
  } scl_state_e;

endpackage

// file: design/scl_sync.sv
/*
  Two-flop synchroniser, one chain per bit.
  Assumes inputs come from outside the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_r[i]  <= asyncIn[i];
          syncOut[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: design/scl_loader.sv
/*
  Serial configuration loader with its optional pins and AXI4-Lite
  registers. Assumes pins arrive asynchronously; open-drain and
  two-way pins are resolved outside from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_loader
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Configuration clock pin
  input  wire logic              configClockIn,
  output logic                   configClockOut,
  output logic                   configClockOe,
  output logic                   configClockPullUp,
  // Configuration inputs
  input  wire logic              serialConfigInput,
  input  wire logic              configRequestN,
  input  wire logic              chipEnableN,
  // Config-complete open-drain pin
  input  wire logic              configCompleteIn,
  output logic                   configCompleteOut,
  output logic                   configCompleteOe,
  // Optional pins
  input  wire logic              userStartupClock,
  input  wire logic              globalOutputEnable,
  input  wire logic              globalRegisterClearN,
  output logic                   initDoneOut,
  output logic                   initDoneOe,
  // Device-wide controls
  output logic                   ioTristateAll,
  output logic                   registerClearAll,
  output logic                   optionPinPullUp,
  output logic                   userMode,
  // Interrupt
  output logic                   irq
);

  logic [7:0]             pinS;
  logic                   clkS, dataS, reqS, ceS;
  logic                   uclkS, goeS, clrS, doneInS;
  scl_state_e             state_r, state_nxt;
  logic [1:0]             ctrl_r;
  logic                   asMode_r;
  logic                   clkPrev_r, uclkPrev_r;
  logic                   psRise, uclkRise, asRise, bitTake;
  logic                   asClk_r;
  logic [CNT_W-1:0]       divCnt_r;
  logic [FRAME_BITS-1:0]  frameSr_r;
  logic [BIT_CNT_W-1:0]   bitCnt_r;
  logic [FRAME_CNT_W-1:0] frameCnt_r;
  logic [31:0]            options_r;
  logic [31:0]            frameWord;
  logic                   frameDone;
  logic [CNT_W-1:0]       initCnt_r;
  logic                   initTick;
  logic                   userClkEn, initDoneEn, goeEn, clrEn;
  logic [IRQ_W-1:0]       irqStat_r, irqMask_r, irqEvt;
  logic                   awHeld_r, wHeld_r;
  logic [ADDR_W-1:0]      awAddr_r;
  logic [31:0]            wData_r;
  logic                   doWrite, takeRead;
  logic [31:0]            rdVal;
  logic                   rdHit;

  // Every pin input crosses two flops first
  scl_sync #(.W(8)) u_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .asyncIn({configClockIn, serialConfigInput, configRequestN,
              chipEnableN, userStartupClock, globalOutputEnable,
              globalRegisterClearN, configCompleteIn}),
    .syncOut(pinS)
  );
  assign {clkS, dataS, reqS, ceS, uclkS, goeS, clrS, doneInS} = pinS;

  assign userClkEn  = options_r[OPT_USER_CLK];
  assign initDoneEn = options_r[OPT_INIT_DONE];
  assign goeEn      = options_r[OPT_GLOBAL_OE];
  assign clrEn      = options_r[OPT_GLOBAL_CLR];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_r  <= 1'b0;
      uclkPrev_r <= 1'b0;
    end else begin
      clkPrev_r  <= clkS;
      uclkPrev_r <= uclkS;
    end
  end

  assign psRise   = clkS & ~clkPrev_r;
  assign uclkRise = uclkS & ~uclkPrev_r;

  // Active mode clock divider, runs only while loading
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= '0;
      asClk_r  <= 1'b0;
    end else if (state_r != ST_LOAD || !asMode_r) begin
      divCnt_r <= '0;
      asClk_r  <= 1'b0;
    end else if (divCnt_r == CNT_W'(AS_HALF_CYC - 1)) begin
      divCnt_r <= '0;
      asClk_r  <= ~asClk_r;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
    end
  end

  assign asRise = (divCnt_r == CNT_W'(AS_HALF_CYC - 1)) & ~asClk_r;
  // Pin edges outside loading are ignored
  assign bitTake = (state_r == ST_LOAD) & ~ceS
                   & (asMode_r ? asRise : psRise);

  // Shift in arrival order, first bit ends up in the MSB
  assign frameWord = {frameSr_r[FRAME_BITS-2:0], dataS};
  assign frameDone = bitTake & (bitCnt_r == BIT_CNT_W'(FRAME_BITS - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frameSr_r <= '0;
    end else if (bitTake) begin
      frameSr_r <= frameWord;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_r   <= '0;
      frameCnt_r <= '0;
    end else if (state_r == ST_RESET) begin
      bitCnt_r   <= '0;
      frameCnt_r <= '0;
    end else if (bitTake) begin
      bitCnt_r <= bitCnt_r + 1'b1;
      if (frameDone) begin
        frameCnt_r <= frameCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      options_r <= '0;
    end else if (state_r == ST_RESET) begin
      options_r <= '0;
    end else if (frameDone && frameCnt_r == '0) begin
      options_r <= frameWord;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      asMode_r <= 1'b0;
    end else if (state_r == ST_RESET) begin
      asMode_r <= ctrl_r[CTRL_AS_BIT];
    end
  end

  // User clock paces start-up when enabled
  assign initTick = userClkEn ? uclkRise : 1'b1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      initCnt_r <= '0;
    end else if (state_r != ST_INIT) begin
      initCnt_r <= '0;
    end else if (initTick) begin
      initCnt_r <= initCnt_r + 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        if (reqS && ctrl_r[CTRL_EN_BIT]) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (frameDone && frameCnt_r == FRAME_CNT_W'(FRAME_COUNT - 1)) begin
          state_nxt = (frameWord == END_WORD) ? ST_INIT : ST_FAIL;
        end
      end
      ST_INIT: begin
        if (initTick && initCnt_r == CNT_W'(INIT_CYCLES - 1)) begin
          state_nxt = ST_USER;
        end
      end
      ST_USER: state_nxt = ST_USER;
      ST_FAIL: state_nxt = ST_FAIL;
      default: state_nxt = ST_RESET;
    endcase
    if (!reqS) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pin drives
  assign configClockOut    = asClk_r;
  assign configClockOe     = asMode_r & (state_r == ST_LOAD);
  assign configClockPullUp = asMode_r;
  assign configCompleteOut = 1'b0;
  assign configCompleteOe  = (state_r != ST_INIT)
                             & (state_r != ST_USER);
  assign initDoneOut       = 1'b0;
  // Options clear in reset, so the pin floats then
  assign initDoneOe        = initDoneEn & ((state_r == ST_LOAD)
                             | (state_r == ST_INIT) | (state_r == ST_FAIL));
  assign userMode          = (state_r == ST_USER);
  assign optionPinPullUp   = ~userMode;
  assign ioTristateAll     = ~userMode | (goeEn & ~goeS);
  assign registerClearAll  = clrEn & ~clrS;

  // Interrupt events, sticky, cleared by reading
  assign irqEvt[IRQ_FRAME]    = frameDone;
  assign irqEvt[IRQ_COMPLETE] = (state_r == ST_LOAD) & (state_nxt == ST_INIT);
  assign irqEvt[IRQ_USER]     = (state_r == ST_INIT) & (state_nxt == ST_USER);
  assign irqEvt[IRQ_FAIL]     = (state_r == ST_LOAD) & (state_nxt == ST_FAIL);

  assign takeRead = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= '0;
    end else if (takeRead && s_axi_araddr == REG_IRQ_STAT) begin
      irqStat_r <= irqEvt;
    end else begin
      irqStat_r <= irqStat_r | irqEvt;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  // Write channel, address and data in either order
  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready  = ~wHeld_r;
  assign doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= '0;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Byte lane 0 holds every writable field
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RESET;
      irqMask_r <= IRQ_MASK_RESET;
    end else if (doWrite && s_axi_wstrb[0]) begin
      if (awAddr_r == REG_CTRL) begin
        ctrl_r <= wData_r[1:0];
      end
      if (awAddr_r == REG_IRQ_MASK) begin
        irqMask_r <= wData_r[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_r == REG_CTRL || awAddr_r == REG_IRQ_MASK)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_comb begin
    rdHit = 1'b1;
    rdVal = '0;
    unique case (s_axi_araddr)
      REG_CTRL:     rdVal = {30'h0, ctrl_r};
      REG_STATUS:   rdVal = {25'h0, doneInS, asMode_r, state_r};
      REG_FRAMES:   rdVal = {24'h0, frameCnt_r};
      REG_OPTIONS:  rdVal = options_r;
      REG_IRQ_STAT: rdVal = {28'h0, irqStat_r};
      REG_IRQ_MASK: rdVal = {28'h0, irqMask_r};
      default:      rdHit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (takeRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdVal;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_enter_user;
    (state_r == ST_INIT) ##1 (state_r == ST_USER);
  endsequence

  chk_ps_capture: assert property (
    bitTake && !asMode_r |=> frameSr_r[0] == $past(dataS))
    else $error("passive bit not captured");
  chk_as_drive: assert property (
    state_r == ST_LOAD && asMode_r |-> configClockOe && configClockPullUp)
    else $error("active clock not driven");
  chk_clock_tristate: assert property (
    state_r != ST_LOAD |-> !configClockOe && !bitTake)
    else $error("clock pin active after load");
  chk_done_float: assert property (
    !reqS |=> !initDoneOe)
    else $error("init-done driven under request");
  chk_done_low: assert property (
    frameDone && frameCnt_r == '0 && frameWord[OPT_INIT_DONE] && reqS
    |=> initDoneOe)
    else $error("init-done not driven low");
  chk_done_release: assert property (
    s_enter_user |-> !initDoneOe && userMode && !configCompleteOe)
    else $error("init-done not released");
  chk_user_clock: assert property (
    state_r == ST_INIT && userClkEn && !uclkRise
    |=> $stable(initCnt_r))
    else $error("init advanced without user clock");
  chk_complete_low: assert property (
    state_r == ST_LOAD |-> configCompleteOe [*1] ##1
    (configCompleteOe || state_r == ST_INIT))
    else $error("config-complete released early");
  chk_output_enable: assert property (
    goeEn && !goeS |-> ioTristateAll)
    else $error("global output enable ignored");
  chk_global_clear: assert property (
    clrEn && !clrS |-> registerClearAll)
    else $error("global clear ignored");

endmodule
`default_nettype wire

// file: verif/scl_host_model.sv
/*
  Passive configuration host: paces the clock pin and serial data.
  Assumes the bench resolves the clock pin from the device enable.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
  // Pins toward the device
  output logic clkPin,
  output logic dataPin,
  // Progress
  output var int bitsSent
);
  initial begin
    clkPin = 1'h0;
    dataPin = 1'h1;
    bitsSent = 0;
  end

  // Clock parked low outside frames, 320 ns period inside
  task automatic send(input logic [31:0] w[$]);
    bitsSent = 0;
    #7;
    foreach (w[i]) begin
      for (int b = 31; b >= 0; b--) begin
        dataPin = w[i][b];
        #160 clkPin = 1'h1;
        #160 clkPin = 1'h0;
        bitsSent++;
      end
    end
    // Released line must not look like a held last bit
    dataPin = ~dataPin;
  endtask

  // Stray edges after configuration, parked low again
  task automatic toggle(input int n);
    repeat (n) begin
      #160 clkPin = 1'h1;
      #160 clkPin = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/serial_config_pin_logic_bench.sv
/*
  Self-checking bench for the serial configuration loader.
  Assumes scl_pkg constants and the host model on the clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_config_pin_logic_bench;
  import scl_pkg::*;
  logic        clock, rst_n, awv, awr, wv, wrd, bv, brd;
  logic        arv, arr, rv, rrd, ckIn, ckOut, ckOe, ckPu;
  logic        hostClk, hostData, reqN, cdIn, cdOe, gOe, gClrN;
  logic        idOe, ioTri, regClr, optPu, userMode, irq, ucRun;
  logic        cdOut, idOut, idPin;
  logic        usc = 1'h0;
  logic [2:0]  ucCnt = 3'h0;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rData;
  logic [1:0]  bRsp, rRsp;
  logic [15:0] seed = 16'h5DB1;
  int          bitsSent, rises, n_mismatch, compares;

  // Open-drain and shared clock pin resolution
  assign ckIn = ckOe ? ckOut : hostClk;
  assign cdIn = cdOe ? cdOut : 1'h1;
  // Init-done pin with its outside pull-up
  assign idPin = idOe ? idOut : 1'h1;

  scl_loader i_dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bRsp), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rData), .s_axi_rresp(rRsp),
    .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .configClockIn(ckIn), .configClockOut(ckOut), .configClockOe(ckOe),
    .configClockPullUp(ckPu), .serialConfigInput(hostData),
    .configRequestN(reqN), .chipEnableN(1'h0),
    .configCompleteIn(cdIn), .configCompleteOut(cdOut),
    .configCompleteOe(cdOe),
    .userStartupClock(usc), .globalOutputEnable(gOe),
    .globalRegisterClearN(gClrN), .initDoneOut(idOut), .initDoneOe(idOe),
    .ioTristateAll(ioTri), .registerClearAll(regClr),
    .optionPinPullUp(optPu), .userMode(userMode), .irq(irq)
  );

  scl_host_model i_host (
    .clkPin(hostClk), .dataPin(hostData), .bitsSent(bitsSent)
  );

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // User start-up clock, 8 system clocks a period while enabled
  always @(posedge clock) begin
    if (ucRun) begin
      ucCnt <= ucCnt + 3'h1;
      usc <= ucCnt[2];
    end
  end

  // Release of the init-done line seen by outside logic
  always @(posedge idPin) begin
    if (rst_n === 1'h1) rises++;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] nextWord();
    logic [15:0] hi;
    seed = lfsr(seed);
    hi = seed;
    seed = lfsr(seed);
    return {hi, seed};
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrReg(input logic [4:0] a, input logic [31:0] d,
                       input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    @(posedge clock);
    awa <= a;
    wd <= d;
    {awv, wv, brd} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      r = bRsp;
      @(posedge clock);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tb) break;
    end
    if (n == 50) n_mismatch++;
    brd <= 1'h0;
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rdReg(input logic [4:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    logic ta, tr;
    int n;
    @(posedge clock);
    ara <= a;
    {arv, rrd} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      ta = arv && arr;
      tr = rv;
      d = rData;
      r = rRsp;
      @(posedge clock);
      if (ta) arv <= 1'h0;
      if (tr) break;
    end
    if (n == 50) n_mismatch++;
    rrd <= 1'h0;
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rdReg(a, d, r);
    cmp("rdata", e, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic waitBits(input int k);
    for (int n = 0; n < 3000; n++) begin
      @(posedge clock);
      if (bitsSent >= k) break;
    end
    if (bitsSent < k) n_mismatch++;
    @(negedge clock);
  endtask

  task automatic pulseReq();
    @(posedge clock);
    reqN <= 1'h0;
    repeat (5) @(negedge clock);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end

  initial begin
    logic [31:0] q[$];
    logic [31:0] d;
    logic [1:0] r;
    int p;
    int n;
    rst_n = 1'h0;
    {awv, wv, brd, arv, rrd, ucRun} = 6'h0;
    {awa, ara, wd} = 42'h0;
    {reqN, gOe, gClrN} = 3'h7;
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    rdChk(REG_CTRL, 32'h0, RESP_OKAY);
    rdChk(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rdChk(REG_STATUS, 32'h1, RESP_OKAY);
    rdChk(5'h18, 32'h0, RESP_SLVERR);
    wrReg(REG_FRAMES, 32'h5, RESP_SLVERR);
    @(negedge clock);
    cmp("initDoneOe", 1'h0, idOe);
    cmp("optionPinPullUp", 1'h1, optPu);
    $display("Test reset done");
    q = {32'hF, nextWord(), nextWord(), END_WORD};
    wrReg(REG_IRQ_MASK, 32'hF, RESP_OKAY);
    wrReg(REG_CTRL, 32'h2, RESP_OKAY);
    fork
      i_host.send(q);
    join_none
    waitBits(40);
    cmp("initDoneOe", 1'h1, idOe);
    cmp("configClockOe", 1'h0, ckOe);
    cmp("configCompleteOe", 1'h1, cdOe);
    waitBits(128);
    repeat (100) @(negedge clock);
    cmp("userMode", 1'h0, userMode);
    @(posedge clock);
    ucRun <= 1'h1;
    for (n = 0; n < 400 && userMode !== 1'h1; n++) @(negedge clock);
    cmp("userMode", 1'h1, userMode);
    cmp("initDoneOe", 1'h0, idOe);
    cmp("initDoneRises", 32'h1, rises);
    cmp("configCompleteOe", 1'h0, cdOe);
    cmp("optionPinPullUp", 1'h0, optPu);
    rdChk(REG_FRAMES, 32'(q.size()), RESP_OKAY);
    rdChk(REG_OPTIONS, q[0], RESP_OKAY);
    rdChk(REG_STATUS, 32'h48, RESP_OKAY);
    @(negedge clock);
    cmp("irq", 1'h1, irq);
    rdChk(REG_IRQ_STAT, 32'h7, RESP_OKAY);
    @(negedge clock);
    cmp("irq", 1'h0, irq);
    @(posedge clock);
    gOe <= 1'h0;
    repeat (5) @(negedge clock);
    cmp("ioTristateAll", 1'h1, ioTri);
    @(posedge clock);
    gOe <= 1'h1;
    gClrN <= 1'h0;
    repeat (5) @(negedge clock);
    cmp("ioTristateAll", 1'h0, ioTri);
    cmp("registerClearAll", 1'h1, regClr);
    @(posedge clock);
    gClrN <= 1'h1;
    repeat (5) @(negedge clock);
    cmp("registerClearAll", 1'h0, regClr);
    i_host.toggle(12);
    rdChk(REG_FRAMES, 32'(q.size()), RESP_OKAY);
    @(negedge clock);
    cmp("userMode", 1'h1, userMode);
    cmp("configClockOe", 1'h0, ckOe);
    pulseReq();
    cmp("initDoneOe", 1'h0, idOe);
    cmp("userMode", 1'h0, userMode);
    rdChk(REG_OPTIONS, 32'h0, RESP_OKAY);
    @(posedge clock);
    reqN <= 1'h1;
    $display("Test passive load done");
    q = {32'h0, nextWord(), nextWord(), ~END_WORD};
    wrReg(REG_CTRL, 32'h2, RESP_OKAY);
    fork
      i_host.send(q);
    join_none
    waitBits(40);
    cmp("initDoneOe", 1'h0, idOe);
    waitBits(128);
    repeat (20) @(negedge clock);
    cmp("configCompleteOe", 1'h1, cdOe);
    rdChk(REG_STATUS, 32'h10, RESP_OKAY);
    rdReg(REG_IRQ_STAT, d, r);
    cmp("failIrq", 32'h8, d & 32'h8);
    $display("Test bad stream done");
    pulseReq();
    wrReg(REG_CTRL, 32'h3, RESP_OKAY);
    @(posedge clock);
    reqN <= 1'h1;
    // Request crosses two flops before loading starts
    repeat (4) @(negedge clock);
    rdChk(REG_STATUS, 32'h22, RESP_OKAY);
    @(negedge clock);
    cmp("configClockOe", 1'h1, ckOe);
    cmp("configClockPullUp", 1'h1, ckPu);
    p = ckOut;
    n = 0;
    repeat (32) begin
      @(negedge clock);
      if (ckOut && p == 0) n++;
      p = ckOut;
    end
    cmp("activeClockRises", 32'h8, n);
    $display("Test active clock done");
    close_out();
  end
endmodule
`default_nettype wire
